// ===== design/tlic_pkg.sv
// constants, field positions and carrier types of the interrupt controller
`default_nettype none

package tlic_pkg;

	localparam int NSRC = 11;

	// special function register addresses
	localparam logic [7:0] ADDR_IE = 8'hA8;
	localparam logic [7:0] ADDR_IE2 = 8'hA9;
	localparam logic [7:0] ADDR_IP = 8'hB8;

	// values after reset
	localparam logic [7:0] IE_RST = 8'h00;
	localparam logic [7:0] IE2_RST = 8'hA0;
	localparam logic [7:0] IP_RST = 8'h00;

	// writable bits; the top bit of both narrow registers is absent
	localparam logic [7:0] IP_WMASK = 8'h7F;
	localparam logic [7:0] IE2_WMASK = 8'h77;
	// the absent top bit of the secondary register reads as one
	localparam logic [7:0] IE2_RD_ONES = 8'h80;

	// primary enable register fields
	localparam int IE_GLOBAL_IRQ_GATE = 7;
	localparam int IE_ADC_IRQ_ON = 6;
	localparam int IE_TMR2_IRQ_ON = 5;
	localparam int IE_UART_IRQ_ON = 4;
	localparam int IE_TMR1_IRQ_ON = 3;
	localparam int IE_EXT1_IRQ_ON = 2;
	localparam int IE_TMR0_IRQ_ON = 1;
	localparam int IE_EXT0_IRQ_ON = 0;

	// primary priority register fields
	localparam int IP_ADC_PRIO_HIGH = 6;
	localparam int IP_TMR2_PRIO_HIGH = 5;
	localparam int IP_UART_PRIO_HIGH = 4;
	localparam int IP_TMR1_PRIO_HIGH = 3;
	localparam int IP_EXT1_PRIO_HIGH = 2;
	localparam int IP_TMR0_PRIO_HIGH = 1;
	localparam int IP_EXT0_PRIO_HIGH = 0;

	// secondary enable/priority register fields
	localparam int IE2_TIC_PRIO_HIGH = 6;
	localparam int IE2_SUPPLY_MON_PRIO_HIGH = 5;
	localparam int IE2_SERIAL_PRIO_HIGH = 4;
	localparam int IE2_TIC_IRQ_ON = 2;
	localparam int IE2_SUPPLY_MON_IRQ_ON = 1;
	localparam int IE2_SERIAL_IRQ_ON = 0;

	// source index equals polling rank, 0 polled first
	localparam int SRC_SUPPLY_MON = 0;
	localparam int SRC_WDOG = 1;
	localparam int SRC_EXT0 = 2;
	localparam int SRC_ADC = 3;
	localparam int SRC_TMR0 = 4;
	localparam int SRC_EXT1 = 5;
	localparam int SRC_TMR1 = 6;
	localparam int SRC_SERIAL = 7;
	localparam int SRC_UART = 8;
	localparam int SRC_TMR2 = 9;
	localparam int SRC_TIC = 10;

	function automatic logic [15:0] tlic_vector(input logic [3:0] idx);
		case (idx)
			4'h0: tlic_vector = 16'h0043;
			4'h1: tlic_vector = 16'h005B;
			4'h2: tlic_vector = 16'h0003;
			4'h3: tlic_vector = 16'h0033;
			4'h4: tlic_vector = 16'h000B;
			4'h5: tlic_vector = 16'h0013;
			4'h6: tlic_vector = 16'h001B;
			4'h7: tlic_vector = 16'h003B;
			4'h8: tlic_vector = 16'h0023;
			4'h9: tlic_vector = 16'h002B;
			4'hA: tlic_vector = 16'h0053;
			default: tlic_vector = 16'h0000;
		endcase
	endfunction : tlic_vector

	// first field is the msb, so the supply monitor lands on bit 0
	typedef struct packed {
		logic tic_req;
		logic tmr2_req;
		logic uart_rxtx_req;
		logic serial_xfer_req;
		logic tmr1_overflow;
		logic ext1_req;
		logic tmr0_overflow;
		logic adc_done_req;
		logic ext0_req;
		logic wdog_req;
		logic supply_mon_req;
	} tlic_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} tlic_sfr_t;

	// which service routines are in progress
	typedef enum logic [1:0] {LVL_NONE, LVL_LOW, LVL_HIGH, LVL_BOTH} tlic_lvl_t;

	typedef struct packed {
		logic [7:0] ie;
		logic [6:0] ie2;
		logic [6:0] ip;
		tlic_lvl_t lvl;
		logic valid;
		logic high;
		logic [3:0] idx;
		logic [15:0] vector;
		logic push;
		logic [7:0] rdata;
	} tlic_state_t;

endpackage : tlic_pkg

`default_nettype wire

// ===== design/tlic_arbiter.sv
// two-level fixed-order arbiter over already gated requests
`default_nettype none

module tlic_arbiter import tlic_pkg::*; #(
	parameter int N = NSRC
) (
	input wire logic [N-1:0] i_req,
	input wire logic [N-1:0] i_high,
	output logic o_hit,
	output logic o_high,
	output logic [3:0] o_idx
);

	function automatic logic [4:0] first_set(input logic [N-1:0] v);
		first_set = 5'h00;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = {1'b1, 4'(i)};
			end
		end
	endfunction : first_set

	logic [4:0] hi_pick;
	logic [4:0] lo_pick;

	always_comb begin
		hi_pick = first_set(i_req & i_high);
		lo_pick = first_set(i_req & ~i_high);
		// high level always beats low level
		if (hi_pick[4]) begin
			o_hit = 1'b1;
			o_high = 1'b1;
			o_idx = hi_pick[3:0];
		end else begin
			o_hit = lo_pick[4];
			o_high = 1'b0;
			o_idx = lo_pick[3:0];
		end
	end

endmodule : tlic_arbiter

`default_nettype wire

// ===== design/tlic_top.sv
// two-level interrupt controller: enable/priority registers, nesting, vectors
//
// Overview of operation
// - bit 7 of primary enable is a global gate; zero blocks every source.
// - primary enable bits 6..0: ADC, tmr2, UART, tmr1, ext1, tmr0, ext0.
// - primary priority bits 6..0 set high level for the same seven sources.
// - bit 7 of primary priority and secondary is absent; writes ignored.
// - secondary bits 6,5,4: high level for interval, supply, serial.
// - secondary bits 2,1,0 enable interval counter, supply monitor, serial.
// - two priority levels; a priority bit picks each source's level, except the watchdog, whose level is set by WDOG_PRIO_HIGH.
// - an enabled high request preempts a low service routine in progress.
// - with both levels pending, high level is granted before low level.
// - a routine is never preempted by a request of its own level.
// - equal-level requests go in fixed polling order, supply monitor first.
// - a grant makes the core push its PC, then load the vector.
// - ext0 0003H tmr0 000BH ext1 0013H tmr1 001BH uart 0023H tmr2 002BH
// - adc 0033H serial 003BH supply 0043H interval 0053H wdog 005BH
`default_nettype none

module tlic_top import tlic_pkg::*; #(
	parameter bit ADC_IRQ_PRESENT = 1'b1,
	parameter bit WDOG_PRIO_HIGH = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire tlic_sfr_t i_sfr,
	output logic [7:0] o_sfr_rdata,
	input wire tlic_req_t i_req,
	output logic o_irq_valid,
	output logic [15:0] o_vector,
	input wire logic i_irq_ack,
	output logic o_pc_push,
	input wire logic i_reti,
	output logic [1:0] o_active
);

	tlic_state_t q;
	tlic_state_t d;
	logic [NSRC-1:0] req_v;
	logic [NSRC-1:0] en_v;
	logic [NSRC-1:0] hi_v;
	logic [NSRC-1:0] elig_v;
	logic in_high;
	logic in_low;
	logic take;
	logic arb_hit;
	logic arb_high;
	logic [3:0] arb_idx;

	assign req_v = i_req;
	assign in_high = (q.lvl == LVL_HIGH) || (q.lvl == LVL_BOTH);
	assign in_low = (q.lvl == LVL_LOW) || (q.lvl == LVL_BOTH);
	assign take = i_irq_ack && q.valid;

	// per-source enable and level, indexed by polling rank
	always_comb begin
		en_v[SRC_SUPPLY_MON] = q.ie2[IE2_SUPPLY_MON_IRQ_ON];
		// the watchdog has no enable bit here; only the global gate applies
		en_v[SRC_WDOG] = 1'b1;
		en_v[SRC_EXT0] = q.ie[IE_EXT0_IRQ_ON];
		en_v[SRC_ADC] = q.ie[IE_ADC_IRQ_ON] && ADC_IRQ_PRESENT;
		en_v[SRC_TMR0] = q.ie[IE_TMR0_IRQ_ON];
		en_v[SRC_EXT1] = q.ie[IE_EXT1_IRQ_ON];
		en_v[SRC_TMR1] = q.ie[IE_TMR1_IRQ_ON];
		en_v[SRC_SERIAL] = q.ie2[IE2_SERIAL_IRQ_ON];
		en_v[SRC_UART] = q.ie[IE_UART_IRQ_ON];
		en_v[SRC_TMR2] = q.ie[IE_TMR2_IRQ_ON];
		en_v[SRC_TIC] = q.ie2[IE2_TIC_IRQ_ON];
		hi_v[SRC_SUPPLY_MON] = q.ie2[IE2_SUPPLY_MON_PRIO_HIGH];
		hi_v[SRC_WDOG] = WDOG_PRIO_HIGH;
		hi_v[SRC_EXT0] = q.ip[IP_EXT0_PRIO_HIGH];
		hi_v[SRC_ADC] = q.ip[IP_ADC_PRIO_HIGH];
		hi_v[SRC_TMR0] = q.ip[IP_TMR0_PRIO_HIGH];
		hi_v[SRC_EXT1] = q.ip[IP_EXT1_PRIO_HIGH];
		hi_v[SRC_TMR1] = q.ip[IP_TMR1_PRIO_HIGH];
		hi_v[SRC_SERIAL] = q.ie2[IE2_SERIAL_PRIO_HIGH];
		hi_v[SRC_UART] = q.ip[IP_UART_PRIO_HIGH];
		hi_v[SRC_TMR2] = q.ip[IP_TMR2_PRIO_HIGH];
		hi_v[SRC_TIC] = q.ie2[IE2_TIC_PRIO_HIGH];
		// disabled requests stay pending at the source, just masked here
		elig_v = req_v & en_v & {NSRC{q.ie[IE_GLOBAL_IRQ_GATE]}};
		// high only when no high routine runs, low only when idle
		elig_v = elig_v & ((hi_v & {NSRC{!in_high}})
			| (~hi_v & {NSRC{q.lvl == LVL_NONE}}));
	end

	// the polling order is the index order; watchdog sits at rank 1
	tlic_arbiter #(
		.N(NSRC)
	) u_arb (
		.i_req(elig_v),
		.i_high(hi_v),
		.o_hit(arb_hit),
		.o_high(arb_high),
		.o_idx(arb_idx)
	);

	always_comb begin
		d = q;
		d.push = 1'b0;
		// register writes; absent bits are dropped by the masks
		if (i_sfr.we) begin
			case (i_sfr.addr)
				ADDR_IE: d.ie = i_sfr.wdata;
				ADDR_IP: d.ip = i_sfr.wdata[6:0] & IP_WMASK[6:0];
				ADDR_IE2: d.ie2 = i_sfr.wdata[6:0] & IE2_WMASK[6:0];
				default: d.ie = q.ie;
			endcase
		end
		// read data comes one cycle after the strobe
		if (i_sfr.re) begin
			case (i_sfr.addr)
				ADDR_IE: d.rdata = q.ie;
				ADDR_IP: d.rdata = {1'b0, q.ip};
				ADDR_IE2: d.rdata = {1'b0, q.ie2} | IE2_RD_ONES;
				default: d.rdata = 8'h00;
			endcase
		end
		// a return closes the innermost routine first
		if (i_reti) begin
			case (q.lvl)
				LVL_BOTH: d.lvl = LVL_LOW;
				LVL_HIGH: d.lvl = LVL_NONE;
				LVL_LOW: d.lvl = LVL_NONE;
				default: d.lvl = LVL_NONE;
			endcase
		end
		if (take) begin
			// the grant is one cycle of push with the vector held
			d.push = 1'b1;
			d.valid = 1'b0;
			if (q.high) begin
				d.lvl = in_low ? LVL_BOTH : LVL_HIGH;
			end else begin
				d.lvl = LVL_LOW;
			end
		end else begin
			d.valid = arb_hit;
			d.high = arb_high;
			d.idx = arb_idx;
			d.vector = tlic_vector(arb_idx);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q <= '{ie: IE_RST, ie2: IE2_RST[6:0], ip: IP_RST[6:0],
				lvl: LVL_NONE, valid: 1'b0, high: 1'b0, idx: 4'h0,
				vector: 16'h0000, push: 1'b0, rdata: 8'h00};
		end else begin
			q <= d;
		end
	end

	assign o_sfr_rdata = q.rdata;
	assign o_irq_valid = q.valid;
	assign o_vector = q.vector;
	assign o_pc_push = q.push;
	assign o_active = {in_high, in_low};

	// helper copies of the previous cycle's view, read only by assertions
	logic [NSRC-1:0] elig_q;
	logic [NSRC-1:0] hi_q;
	logic [NSRC-1:0] lower_q;
	logic gate_q;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			elig_q <= 11'h000;
			hi_q <= 11'h000;
			gate_q <= 1'b0;
		end else begin
			elig_q <= elig_v;
			hi_q <= hi_v;
			gate_q <= q.ie[IE_GLOBAL_IRQ_GATE];
		end
	end
	always_comb begin
		lower_q = (11'h001 << q.idx) - 11'h001;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	gate_off_a: assert property (
		!q.ie[IE_GLOBAL_IRQ_GATE] |=> !o_irq_valid)
		else $error("request offered while global gate is off");

	enabled_src_a: assert property (
		o_irq_valid |-> elig_q[q.idx] && gate_q)
		else $error("offered source was not enabled");

	level_sel_a: assert property (
		o_irq_valid |-> q.high == hi_q[q.idx])
		else $error("offered level does not match priority bit");

	absent_bit_a: assert property (
		i_sfr.re && (i_sfr.addr == ADDR_IP || i_sfr.addr == ADDR_IE2)
		|=> o_sfr_rdata[7] == ($past(i_sfr.addr) == ADDR_IE2))
		else $error("absent top bit read wrong");

	sec_write_a: assert property (
		i_sfr.we && i_sfr.addr == ADDR_IE2
		|=> q.ie2 == ($past(i_sfr.wdata[6:0]) & IE2_WMASK[6:0]))
		else $error("secondary register write not stored");

	prim_write_a: assert property (
		i_sfr.we && i_sfr.addr == ADDR_IE |=> q.ie == $past(i_sfr.wdata))
		else $error("primary enable write not stored");

	same_level_a: assert property (
		in_high |-> ##1 (!o_irq_valid || $past(i_reti) || !$past(in_high)))
		else $error("request offered inside a high routine");

	preempt_low_a: assert property (
		o_irq_valid && in_low && !$past(i_reti) |-> q.high)
		else $error("low request offered inside a low routine");

	high_first_a: assert property (
		o_irq_valid && !q.high |-> (elig_q & hi_q) == 11'h000)
		else $error("low granted while high pending");

	poll_order_a: assert property (
		o_irq_valid |-> (elig_q & ~(hi_q ^ {NSRC{q.high}}) & lower_q)
		== 11'h000)
		else $error("polling order violated");

	push_pulse_a: assert property (
		take |=> o_pc_push && o_vector == $past(o_vector) ##1 !o_pc_push)
		else $error("grant did not give one push with held vector");

	vector_map_a: assert property (
		o_pc_push |-> o_vector == tlic_vector(q.idx))
		else $error("vector does not match granted source");

	reset_vals_a: assert property (
		$fell(i_sys_rst) |-> q.ie == IE_RST && q.ip == IP_RST[6:0]
		&& q.ie2 == IE2_RST[6:0] && !o_irq_valid && !o_pc_push)
		else $error("state after reset differs from reset values");

	bit3_zero_a: assert property (
		i_sfr.re && i_sfr.addr == ADDR_IE2 |=> o_sfr_rdata[3] == 1'b0)
		else $error("secondary bit 3 read back as one");

	prio_write_a: assert property (
		i_sfr.we && i_sfr.addr == ADDR_IP
		|=> q.ip == $past(i_sfr.wdata[6:0]))
		else $error("priority write not stored");

	prio_read_a: assert property (
		i_sfr.re && i_sfr.addr == ADDR_IP
		|=> o_sfr_rdata == {1'b0, $past(q.ip)})
		else $error("priority register read wrong");

	en_read_a: assert property (
		i_sfr.re && i_sfr.addr == ADDR_IE
		|=> o_sfr_rdata == $past(q.ie))
		else $error("primary enable read wrong");

	ack_ignored_a: assert property (
		i_irq_ack && !o_irq_valid |=> !o_pc_push)
		else $error("push without an offered request");

	push_cause_a: assert property (
		o_pc_push |-> $past(i_irq_ack) && $past(o_irq_valid))
		else $error("push without an acknowledge");

	push_idle_a: assert property (
		o_pc_push |-> !o_irq_valid)
		else $error("offer shown during push");

	low_nest_a: assert property (
		take && !q.high |=> q.lvl == LVL_LOW)
		else $error("low grant did not open a low routine");

	high_nest_a: assert property (
		take && q.high |=> in_high)
		else $error("high grant did not open a high routine");

	ret_inner_a: assert property (
		i_reti && !take && q.lvl == LVL_BOTH |=> q.lvl == LVL_LOW)
		else $error("return from nested high did not resume low");

	ret_last_a: assert property (
		i_reti && !take && q.lvl != LVL_BOTH |=> q.lvl == LVL_NONE)
		else $error("return did not close the routine");

	lvl_hold_a: assert property (
		!i_reti && !take |=> $stable(q.lvl))
		else $error("routine level changed without grant or return");

	wdog_first_a: assert property (
		o_irq_valid && q.idx == SRC_EXT0
		|-> !(elig_q[SRC_WDOG] && hi_q[SRC_WDOG] == q.high))
		else $error("external 0 offered ahead of watchdog");

	adc_absent_a: assert property (
		o_irq_valid |-> ADC_IRQ_PRESENT || q.idx != SRC_ADC)
		else $error("converter source offered on a variant without it");

	nest_cov: cover property (q.lvl == LVL_LOW ##[1:20] q.lvl == LVL_BOTH);
	grant_cov: cover property (take ##1 o_pc_push);
	tie_cov: cover property (o_irq_valid && q.idx == 4'h1 && elig_q[SRC_EXT0]);
	ret_cov: cover property (q.lvl == LVL_BOTH ##1 q.lvl == LVL_LOW);
	pre_cov: cover property (o_irq_valid && q.high && in_low);

endmodule : tlic_top

`default_nettype wire

// ===== verif/tlic_core_model.sv
// core-side model: acknowledges an offer after a set lag, loads the vector
`default_nettype none
module tlic_core_model (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_irq_valid,
	input wire logic [15:0] i_vector,
	input wire logic i_pc_push,
	input wire logic i_take,
	input wire logic [1:0] i_lag,
	output logic o_irq_ack,
	output logic [15:0] o_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_q;
	// the lag restarts whenever the offer is withdrawn, as a slow core would
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !i_irq_valid || !i_take || o_irq_ack) begin
			cnt_q <= 2'h0;
			o_irq_ack <= 1'b0;
		end else if (cnt_q == i_lag) begin
			o_irq_ack <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 2'h1;
		end
		if (i_sys_rst) begin
			o_pc <= 16'h0000;
		end else if (i_pc_push) begin
			o_pc <= i_vector;
		end
	end
endmodule : tlic_core_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the two-level interrupt controller
`default_nettype none
module tb;
	import tlic_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic rst = 1'b1;
	tlic_sfr_t sfr = '0;
	tlic_req_t req = '0;
	logic reti = 1'b0;
	logic take = 1'b0;
	logic [1:0] lag = 2'h0;
	logic [7:0] rdata;
	logic valid;
	logic [15:0] vec;
	logic ack;
	logic push;
	logic [1:0] active;
	logic [15:0] pc;
	int bad_count = 0;
	int checked = 0;
	logic [7:0] en_a [10] = '{8'hA8, 8'hA8, 8'hA8, 8'hA8, 8'hA8, 8'hA8,
		8'hA8, 8'hA9, 8'hA9, 8'hA9};
	logic [7:0] en_d [10] = '{8'hC0, 8'hA0, 8'h90, 8'h88, 8'h84, 8'h82,
		8'h81, 8'h04, 8'h02, 8'h01};
	logic [15:0] en_v [10] = '{16'h0033, 16'h002B, 16'h0023, 16'h001B,
		16'h0013, 16'h000B, 16'h0003, 16'h0053, 16'h0043, 16'h003B};
	// expected grant order with every source at the low level
	logic [15:0] ord [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033,
		16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};

	always #5 i_clk = ~i_clk;

	tlic_top #(.WDOG_PRIO_HIGH(1'b0)) u_tlic_top (.i_clk(i_clk),
		.i_sys_rst(rst), .i_sfr(sfr), .o_sfr_rdata(rdata), .i_req(req),
		.o_irq_valid(valid), .o_vector(vec), .i_irq_ack(ack),
		.o_pc_push(push), .i_reti(reti), .o_active(active));
	tlic_core_model u_tlic_core_model (.i_clk(i_clk), .i_sys_rst(rst),
		.i_irq_valid(valid), .i_vector(vec), .i_pc_push(push),
		.i_take(take), .i_lag(lag), .o_irq_ack(ack), .o_pc(pc));

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, d);
		sfr <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clk);
		sfr <= '0;
		@(posedge i_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, exp);
		sfr <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge i_clk);
		sfr <= '0;
		@(negedge i_clk);
		chk("rdata", {8'h00, rdata}, {8'h00, exp});
		@(posedge i_clk);
	endtask : rd

	// bounded wait for an offer or a push, then check the vector shown
	task automatic offer(input logic [15:0] exp, input logic want_push);
		int n;
		for (n = 0; n < 20; n++) begin
			@(negedge i_clk);
			if ((want_push ? push : valid) === 1'b1)
				break;
		end
		if (n == 20) begin
			bad_count++;
			tally_and_finish();
		end else begin
			chk("vector", vec, exp);
			@(posedge i_clk);
		end
	endtask : offer

	task automatic ret;
		reti <= 1'b1;
		@(posedge i_clk);
		reti <= 1'b0;
		@(posedge i_clk);
	endtask : ret

	initial begin
		repeat (10) @(posedge i_clk);
		rst <= 1'b0;
		@(posedge i_clk);
		rd(ADDR_IE, 8'h00);
		rd(ADDR_IE2, 8'hA0);
		rd(8'hC0, 8'h00);
		rd(ADDR_IP, 8'h00);
		wr(ADDR_IP, 8'hFF);
		rd(ADDR_IP, 8'h7F);
		wr(ADDR_IE2, 8'h77);
		rd(ADDR_IE2, 8'hF7);
		wr(ADDR_IP, 8'h00);
		wr(ADDR_IE2, 8'h07);
		wr(ADDR_IE, 8'h7F);
		req <= 11'h7FF;
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		chk("valid", {15'h0, valid}, 16'h0000);
		@(posedge i_clk);
		req <= 11'h7FD;
		for (int i = 0; i < 10; i++) begin
			wr(ADDR_IE, 8'h80);
			wr(ADDR_IE2, 8'h00);
			wr(en_a[i], en_d[i]);
			offer(en_v[i], 1'b0);
		end
		wr(ADDR_IE, 8'hFF);
		wr(ADDR_IE2, 8'h07);
		req <= 11'h7FF;
		take <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			offer(ord[i], 1'b1);
			req <= req & ~(11'h001 << i);
			@(negedge i_clk);
			chk("pc", pc, ord[i]);
			chk("valid", {15'h0, valid}, 16'h0000);
			@(posedge i_clk);
			ret();
		end
		lag <= 2'h2;
		wr(ADDR_IP, 8'h20);
		req <= 11'h204;
		offer(16'h002B, 1'b1);
		req <= 11'h004;
		ret();
		offer(16'h0003, 1'b1);
		req <= 11'h220;
		offer(16'h002B, 1'b1);
		@(negedge i_clk);
		chk("active", {14'h0, active}, 16'h0003);
		@(posedge i_clk);
		req <= 11'h020;
		ret();
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		chk("active", {14'h0, active}, 16'h0001);
		chk("valid", {15'h0, valid}, 16'h0000);
		@(posedge i_clk);
		ret();
		offer(16'h0013, 1'b1);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
